// file: core/option_word_decoder.sv
// Captures the one-time option words at reset release and holds controls.
//
// Summary of operation
// - Option words sit outside program memory; the CPU cannot read them.
// - Store holds two 13-bit words, word 0 options, word 1 identity.
// - Word 0 bit 12: 0 RC oscillator, 1 crystal oscillator.
// - Word 0 bit 11 low enables the watchdog; high disables it.
// - Word 0 bit 10: 0 two, 1 four oscillator periods per cycle.
// - Word 0 bit 9 low turns code protection on.
// - Word 0 bit 8: 0 low-frequency crystal, 1 high-frequency crystal.
// - Range bit acts only with crystal type; programmer writes it 0 otherwise.
// - Word 0 bit 7 is reserved, always 1, and drives only the reserved_bit_error flag.
// - Word 0 bit 6: 0 low oscillator power, 1 high power.
// - Customer ID is word 0 bits 5..0 plus all of word 1.
// - Four-period cycle feeds the timer with Fosc/4 instead of Fosc/2.
`timescale 1ns/1ps
module option_word_decoder
  import option_word_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Programmed option store, read by this block only
  input wire logic [12:0] otp_word0,
  input wire logic [12:0] otp_word1,
  // Decoded controls
  output option_word_pkg::option_ctrl_t ctrl,
  output logic ctrl_valid,
  output logic reserved_bit_error
);
  import option_word_pkg::*;

  // ------------------------------------------------------------
  // Private copy of the store
  // ------------------------------------------------------------

  // The words have no path to the program bus; only this block sees them.
  logic [12:0] word0;
  logic [12:0] word1;
  load_state_t state;
  option_ctrl_t next_ctrl;

  option_field_map u_map (
    .word0(word0),
    .word1(word1),
    .ctrl(next_ctrl)
  );

  // ------------------------------------------------------------
  // Loader sequence
  // ------------------------------------------------------------

  // Idle one cycle after release, capture, then lock until reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= ST_CAPTURE;
        ST_CAPTURE: state <= ST_LOCKED;
        ST_LOCKED: state <= ST_LOCKED;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Sampling happens clocked after release, never under the reset itself.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word0 <= WORD0_RST;
      word1 <= WORD1_RST;
    end else if (state == ST_IDLE) begin
      word0 <= otp_word0;
      word1 <= otp_word1;
    end
  end

  // Outputs are registered and frozen once locked.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= '0;
      ctrl_valid <= 1'b0;
      reserved_bit_error <= 1'b0;
    end else if (state == ST_CAPTURE) begin
      ctrl <= next_ctrl;
      ctrl_valid <= 1'b1;
      // Flag only; the reserved bit drives no function.
      reserved_bit_error <= ~word0[RSVD_BIT];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------

  property p_frozen;
    @(posedge clk) disable iff (!rst_b)
      ctrl_valid |=> ($stable(ctrl) && ctrl_valid);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("controls changed after lock");

  property p_valid_time;
    @(posedge clk) disable iff (!rst_b)
      (state == ST_IDLE) |-> !ctrl_valid ##2 ctrl_valid;
  endproperty
  a_valid_time: assert property (p_valid_time)
    else $error("controls not valid two cycles after release");

  property p_osc_type;
    @(posedge clk) disable iff (!rst_b)
      (state == ST_CAPTURE) |=> ctrl.osc_type_sel == $past(word0[12]);
  endproperty
  a_osc_type: assert property (p_osc_type)
    else $error("oscillator type wrong");

  property p_wdt;
    @(posedge clk) disable iff (!rst_b)
      ctrl_valid |-> ctrl.watchdog_en == ~word0[11];
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog enable wrong");

  property p_cycle;
    @(posedge clk) disable iff (!rst_b)
      ctrl_valid |-> ctrl.four_period_cycle == word0[10];
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("cycle length wrong");

  property p_protect;
    @(posedge clk) disable iff (!rst_b)
      ctrl_valid |-> ctrl.code_protect == ~word0[9];
  endproperty
  a_protect: assert property (p_protect)
    else $error("protection wrong");

  property p_range;
    @(posedge clk) disable iff (!rst_b)
      ctrl_valid |-> (ctrl.crystal_range_sel == (word0[12] & word0[8]))
        && ((ctrl.osc_mode == high_crystal_mode) == (word0[12] & word0[8]));
  endproperty
  a_range: assert property (p_range)
    else $error("range bit acted without crystal");

  property p_power;
    @(posedge clk) disable iff (!rst_b)
      ctrl_valid |-> ctrl.osc_power_sel == word0[6];
  endproperty
  a_power: assert property (p_power)
    else $error("power level wrong");

  property p_id;
    @(posedge clk) disable iff (!rst_b)
      ctrl_valid |-> ctrl.customer_id == {word1, word0[5:0]};
  endproperty
  a_id: assert property (p_id)
    else $error("customer id wrong");

  property p_div;
    @(posedge clk) disable iff (!rst_b)
      ctrl_valid |-> ctrl.timer_div_m1 == (word0[10] ? 2'h3 : 2'h1);
  endproperty
  a_div: assert property (p_div)
    else $error("timer divider wrong");

endmodule

// file: core/option_word_pkg.sv
// Package of constants and types for the option word decoder.
package option_word_pkg;

  // ------------------------------------------------------------
  // Word geometry
  // ------------------------------------------------------------
  localparam int WORD_W = 13;
  localparam int ID_W = 19;

  // ------------------------------------------------------------
  // Field positions in word 0
  // ------------------------------------------------------------
  localparam int OSC_TYPE_BIT = 12;
  localparam int WDT_DIS_BIT = 11;
  localparam int CYCLE_BIT = 10;
  localparam int PROTECT_BIT = 9;
  localparam int RANGE_BIT = 8;
  localparam int RSVD_BIT = 7;
  localparam int POWER_BIT = 6;
  localparam int ID_LO_MSB = 5;

  // ------------------------------------------------------------
  // Reset values: safest settings until the words are captured.
  // ------------------------------------------------------------
  localparam logic [12:0] WORD0_RST = 13'h1_FFF;
  localparam logic [12:0] WORD1_RST = 13'h0_000;
  localparam logic [1:0] DIV_TWO = 2'h1;
  localparam logic [1:0] DIV_FOUR = 2'h3;

  // Oscillator modes.
  typedef enum logic [1:0] {
    rc_oscillator_mode = 2'b00,
    low_crystal_mode = 2'b01,
    high_crystal_mode = 2'b11
  } osc_mode_t;

  // Loader states, Gray coded along the path.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_LOCKED = 2'b11
  } load_state_t;

  // Decoded static controls.
  typedef struct packed {
    logic osc_type_sel;
    logic crystal_range_sel;
    osc_mode_t osc_mode;
    logic watchdog_en;
    logic four_period_cycle;
    logic code_protect;
    logic osc_power_sel;
    logic [1:0] timer_div_m1;
    logic [ID_W-1:0] customer_id;
  } option_ctrl_t;

endpackage

// file: core/option_field_map.sv
// Pure decode of the two option words into static control fields.
`timescale 1ns/1ps
module option_field_map
  import option_word_pkg::*;
(
  // Raw option words
  input wire logic [12:0] word0,
  input wire logic [12:0] word1,
  // Decoded fields
  output option_word_pkg::option_ctrl_t ctrl
);

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------

  // Range bit only matters with a crystal; reserved bit is ignored.
  always_comb begin
    ctrl.osc_type_sel = word0[OSC_TYPE_BIT];
    ctrl.crystal_range_sel = word0[OSC_TYPE_BIT] & word0[RANGE_BIT];
    if (!word0[OSC_TYPE_BIT]) begin
      ctrl.osc_mode = rc_oscillator_mode;
    end else if (word0[RANGE_BIT]) begin
      ctrl.osc_mode = high_crystal_mode;
    end else begin
      ctrl.osc_mode = low_crystal_mode;
    end
    ctrl.watchdog_en = ~word0[WDT_DIS_BIT];
    ctrl.four_period_cycle = word0[CYCLE_BIT];
    ctrl.code_protect = ~word0[PROTECT_BIT];
    ctrl.osc_power_sel = word0[POWER_BIT];
    // Timer clock is Fosc/4 with the long cycle, else Fosc/2.
    ctrl.timer_div_m1 = word0[CYCLE_BIT] ? DIV_FOUR : DIV_TWO;
    ctrl.customer_id = {word1, word0[ID_LO_MSB:0]};
  end

endmodule

// file: verif/testbench.sv
// Self-checking testbench for the option word decoder.
`timescale 1ns/1ps
module testbench;
  import option_word_pkg::*;

  // ------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [12:0] otp_word0 = 13'h1_FFF;
  logic [12:0] otp_word1 = 13'h0_000;
  option_ctrl_t ctrl;
  logic ctrl_valid;
  logic reserved_bit_error;
  int errors = 0;
  int tests_run = 0;
  logic [15:0] lfsr = 16'h0017;
  logic [12:0] dir_w0 [4] = '{13'h0_080, 13'h1_E80, 13'h1_FFF, 13'h1_B7F};

  option_word_decoder option_word_decoder_i (
    .clk(clk),
    .rst_b(rst_b),
    .otp_word0(otp_word0),
    .otp_word1(otp_word1),
    .ctrl(ctrl),
    .ctrl_valid(ctrl_valid),
    .reserved_bit_error(reserved_bit_error)
  );

  // A 5 ns period gives the 200 MHz core clock.
  initial begin
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Model and comparisons
  // ------------------------------------------------------------
  // Galois shift register; fixed start keeps every run repeatable.
  function automatic logic [15:0] step(input logic [15:0] s);
    step = {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction

  // Expected controls, built field by field from the option bits.
  function automatic option_ctrl_t model(input logic [12:0] w0, w1);
    option_ctrl_t e;
    e.osc_type_sel = w0[12];
    e.crystal_range_sel = w0[12] & w0[8];
    e.osc_mode = !w0[12] ? rc_oscillator_mode :
                 (w0[8] ? high_crystal_mode : low_crystal_mode);
    e.watchdog_en = ~w0[11];
    e.four_period_cycle = w0[10];
    e.code_protect = ~w0[9];
    e.osc_power_sel = w0[6];
    e.timer_div_m1 = w0[10] ? 2'h3 : 2'h1;
    e.customer_id = {w1, w0[5:0]};
    model = e;
  endfunction

  task automatic check_ctrl(input option_ctrl_t got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One reset, capture and freeze cycle for one pair of option words.
  task automatic run_one(input logic [12:0] w0, w1);
    @(negedge clk);
    rst_b = 1'b0;
    otp_word0 = w0;
    otp_word1 = w1;
    @(negedge clk);
    check_ctrl(ctrl, '0);
    check_flag(ctrl_valid, 1'b0);
    rst_b = 1'b1;
    @(negedge clk);
    check_flag(ctrl_valid, 1'b0);
    @(negedge clk);
    check_flag(ctrl_valid, 1'b1);
    check_ctrl(ctrl, model(w0, w1));
    check_ctrl(ctrl, model(w0, w1));
    check_flag(reserved_bit_error, ~w0[7]);
    // Words flipped after capture must leave the controls untouched.
    otp_word0 = ~w0;
    otp_word1 = ~w1;
    repeat (3) @(negedge clk);
    check_ctrl(ctrl, model(w0, w1));
    $display("test done: word0 %h word1 %h", w0, w1);
  endtask

  // ------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Directed words cover each oscillator mode and a cleared reserved bit.
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      run_one(dir_w0[i], 13'h1_555);
    end
    for (int i = 0; i < 16; i++) begin
      lfsr = step(lfsr);
      otp_word1 = lfsr[12:0];
      lfsr = step(lfsr);
      run_one(lfsr[12:0], otp_word1);
    end
    summarize();
  end

  // About 20 tests of under 10 cycles each; allow a wide margin.
  initial begin
    #25000;
    errors++;
    summarize();
  end
endmodule
